// File: hdl/core_ctrl_regs.svh
// Register indices, field positions, reset values and core constants
// Assumes AHB-Lite word addressing: byte address is four times the index
//
// Behaviour
// - Global enable low blocks every interrupt; high lets enabled sources interrupt.
// - Peripheral sources interrupt only while peripheral_irq_enable is set.
// - Timer overflow interrupts only while timer_overflow_irq_enable is set.
// - External pin interrupts only while ext_pin_irq_enable is set.
// - Pin-change events interrupt only while pin_change_irq_enable is set.
// - Timer overflow sets its flag; only software clears it.
// - External pin event sets its flag; held until software clears it.
// - Any change on pin_zero, pin_one or pin_three sets the pin-change flag.
// - Flags set on their condition regardless of any enable bit.
// - Program counter is 13 bits; only its low byte is bus visible.
// - Writing pc_low_byte loads upper counter bits from pc_high_latch bits 4..0.
// - Invoke and jump clear the top two counter bits; the target fills bits 10..0.
// - Single program page: page-select bits 4..3 are ignored.
// - Every reset clears the program counter.
// - Return stack: 8 entries of 13 bits, pointer hidden from software.
// - Invoke and interrupt vectoring push the program counter.
// - Return instructions pop into the counter; pc_high_latch untouched.
// - Stack wraps circularly; no overflow or underflow status.
// - Window accesses go to the register addressed by indirect_pointer.
// - Pointer zero: window reads 00h and writes change nothing.
// - Effective indirect address is indirect_bank_bit above the 8-bit pointer.
`ifndef CORE_CTRL_REGS_SVH
`define CORE_CTRL_REGS_SVH

`define IDX_WINDOW 8'h00
`define IDX_PC_LOW 8'h02
`define IDX_BANK_SEL 8'h03
`define IDX_POINTER 8'h04
`define IDX_PC_LATCH 8'h0a
`define IDX_IRQ_CTRL 8'h0b
`define IDX_PIRQ_FLAGS 8'h0c
`define IDX_IRQ_CTRL_ALT 8'h8b
`define IDX_PIRQ_ENABLES 8'h8c
`define IDX_POWER_CTRL 8'h8e

`define BIT_GLOBAL_EN 7
`define BIT_PERIPH_EN 6
`define BIT_TMR_EN 5
`define BIT_EXT_EN 4
`define BIT_CHG_EN 3
`define BIT_TMR_FLAG 2
`define BIT_EXT_FLAG 1
`define BIT_CHG_FLAG 0
`define BIT_BANK 7

`define RST_BYTE 8'h00
`define RST_PC 13'h0000
`define IRQ_VECTOR 13'h0004
`define PAGE_MASK 2'b00
`define STACK_DEPTH 8

`endif

// File: hdl/core_ctrl_pkg.sv
// Types shared by the core control block and its surroundings
// Assumes the instruction logic issues at most one operation per clock
package core_ctrl_pkg;

  typedef enum logic [2:0] {
    OP_NONE,
    OP_STEP,
    OP_INVOKE,
    OP_JUMP,
    OP_RETURN,
    OP_VECTOR
  } core_op_t;

  typedef struct packed {
    core_op_t op;
    logic [10:0] target;
  } core_cmd_t;

  typedef struct packed {
    logic timer_overflow;
    logic ext_pin_event;
    logic [2:0] pins;
    logic [7:0] periph_set;
  } irq_events_t;

endpackage : core_ctrl_pkg

// File: hdl/core_pc_stack_irq_control.sv
// Interrupt control, program counter, return stack and indirect window
// Assumes one AHB-Lite master, word transfers, and synchronous core inputs
`timescale 1ns/10ps
`include "core_ctrl_regs.svh"

module core_pc_stack_irq_control (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire core_ctrl_pkg::core_cmd_t core_cmd,
  input wire core_ctrl_pkg::irq_events_t events,
  output logic [12:0] pc,
  output logic irq_request
);
  import core_ctrl_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Bus phase tracking

  logic dp_valid_ff;
  logic dp_write_ff;
  logic dp_mapped_ff;
  logic [7:0] dp_idx_ff;
  logic hready_ff;
  logic [31:0] hrdata_ff;

  wire accept = hsel & htrans[1] & hready;
  wire addr_in_range = (haddr[31:10] == 22'h00_0000) & (haddr[1:0] == 2'b00);

  // One wait state per transfer, so a write lands before any following read
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      dp_valid_ff <= 1'b0;
      dp_write_ff <= 1'b0;
      dp_mapped_ff <= 1'b0;
      dp_idx_ff <= 8'h00;
      hready_ff <= 1'b1;
    end
    else
    begin
      dp_valid_ff <= accept;
      dp_write_ff <= accept & hwrite;
      dp_mapped_ff <= addr_in_range & (hsize == 3'b010);
      dp_idx_ff <= haddr[9:2];
      hready_ff <= ~accept;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register storage

  logic [7:0] irq_ctrl_ff;
  logic [7:0] pirq_flags_ff;
  logic [7:0] pirq_enables_ff;
  logic [7:0] pointer_ff;
  logic [7:0] pc_latch_ff;
  logic [7:0] power_ctrl_ff;
  logic bank_ff;
  logic [12:0] pc_ff;
  logic [2:0] pins_prev_ff;
  logic irq_ff;
  logic [2:0] sp_ff;
  logic [12:0] stack_ff [`STACK_DEPTH];

  ////////////////////////////////////////////////////////////////////////////
  // Indirect window resolution

  // The window is no storage; it redirects to {bank, pointer}
  wire via_window = (dp_idx_ff == `IDX_WINDOW);
  wire [8:0] eff_addr = {bank_ff, pointer_ff};
  wire window_null = (pointer_ff == 8'h00);
  // The bank bit has no registers behind it, so bank-one targets are void
  wire [8:0] tgt_addr = via_window ? eff_addr : {1'b0, dp_idx_ff};
  wire tgt_void = via_window & window_null;
  wire [7:0] tgt = tgt_addr[7:0];
  wire tgt_ok = dp_mapped_ff & ~tgt_addr[8] & ~tgt_void;

  wire wr_go = dp_valid_ff & dp_write_ff & tgt_ok;
  wire rd_go = dp_valid_ff & ~dp_write_ff;
  wire [7:0] wbyte = hwdata[7:0];

  wire wr_irq_ctrl = wr_go & ((tgt == `IDX_IRQ_CTRL) | (tgt == `IDX_IRQ_CTRL_ALT));
  wire wr_pirq_flags = wr_go & (tgt == `IDX_PIRQ_FLAGS);
  wire wr_pirq_enables = wr_go & (tgt == `IDX_PIRQ_ENABLES);
  wire wr_pointer = wr_go & (tgt == `IDX_POINTER);
  wire wr_pc_latch = wr_go & (tgt == `IDX_PC_LATCH);
  wire wr_pc_low = wr_go & (tgt == `IDX_PC_LOW);
  wire wr_bank = wr_go & (tgt == `IDX_BANK_SEL);
  wire wr_power = wr_go & (tgt == `IDX_POWER_CTRL);

  ////////////////////////////////////////////////////////////////////////////
  // Read selection

  // A void or unmapped target reads as zero, which also covers pointer zero
  wire [7:0] rd_byte =
    !tgt_ok ? 8'h00 :
    ((tgt == `IDX_IRQ_CTRL) | (tgt == `IDX_IRQ_CTRL_ALT)) ? irq_ctrl_ff :
    (tgt == `IDX_PIRQ_FLAGS) ? pirq_flags_ff :
    (tgt == `IDX_PIRQ_ENABLES) ? pirq_enables_ff :
    (tgt == `IDX_POINTER) ? pointer_ff :
    (tgt == `IDX_PC_LATCH) ? pc_latch_ff :
    (tgt == `IDX_PC_LOW) ? pc_ff[7:0] :
    (tgt == `IDX_BANK_SEL) ? {bank_ff, 7'h00} :
    (tgt == `IDX_POWER_CTRL) ? power_ctrl_ff : 8'h00;

  wire [31:0] nxt_hrdata = rd_go ? {24'h00_0000, rd_byte} : hrdata_ff;

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      hrdata_ff <= 32'h0000_0000;
    else
      hrdata_ff <= nxt_hrdata;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Interrupt flags and enables

  wire pin_change = |(events.pins ^ pins_prev_ff);
  // Flags set on their own condition; enables play no part here
  wire [2:0] flag_set = {events.timer_overflow, events.ext_pin_event, pin_change};

  // A set in the same cycle as a software clear wins
  wire [7:0] ctrl_base = wr_irq_ctrl ? wbyte : irq_ctrl_ff;
  wire [7:0] nxt_irq_ctrl = {ctrl_base[7:3], ctrl_base[2:0] | flag_set};
  wire [7:0] pflag_base = wr_pirq_flags ? wbyte : pirq_flags_ff;
  wire [7:0] nxt_pirq_flags = pflag_base | events.periph_set;

  wire tmr_req = irq_ctrl_ff[`BIT_TMR_EN] & irq_ctrl_ff[`BIT_TMR_FLAG];
  wire ext_req = irq_ctrl_ff[`BIT_EXT_EN] & irq_ctrl_ff[`BIT_EXT_FLAG];
  wire chg_req = irq_ctrl_ff[`BIT_CHG_EN] & irq_ctrl_ff[`BIT_CHG_FLAG];
  wire per_req = irq_ctrl_ff[`BIT_PERIPH_EN] & |(pirq_flags_ff & pirq_enables_ff);
  wire nxt_irq = irq_ctrl_ff[`BIT_GLOBAL_EN] & (tmr_req | ext_req | chg_req | per_req);

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      irq_ctrl_ff <= `RST_BYTE;
      pirq_flags_ff <= `RST_BYTE;
      pirq_enables_ff <= `RST_BYTE;
      pins_prev_ff <= 3'b000;
      irq_ff <= 1'b0;
    end
    else
    begin
      irq_ctrl_ff <= nxt_irq_ctrl;
      pirq_flags_ff <= nxt_pirq_flags;
      pirq_enables_ff <= wr_pirq_enables ? wbyte : pirq_enables_ff;
      pins_prev_ff <= events.pins;
      irq_ff <= nxt_irq;
    end
  end

  // Pin history starts at zero, so pins held high at reset flag one change

  ////////////////////////////////////////////////////////////////////////////
  // Plain control registers

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      pointer_ff <= `RST_BYTE;
      pc_latch_ff <= `RST_BYTE;
      power_ctrl_ff <= `RST_BYTE;
      bank_ff <= 1'b0;
    end
    else
    begin
      pointer_ff <= wr_pointer ? wbyte : pointer_ff;
      pc_latch_ff <= wr_pc_latch ? wbyte : pc_latch_ff;
      power_ctrl_ff <= wr_power ? wbyte : power_ctrl_ff;
      bank_ff <= wr_bank ? wbyte[`BIT_BANK] : bank_ff;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Program counter and return stack

  wire do_push = (core_cmd.op == OP_INVOKE) | (core_cmd.op == OP_VECTOR);
  wire do_pop = (core_cmd.op == OP_RETURN);
  wire [2:0] sp_dec = sp_ff - 3'd1;
  // Wrap-around comes free from the 3-bit pointer, no limit is tracked
  wire [2:0] nxt_sp = do_push ? sp_ff + 3'd1 : do_pop ? sp_dec : sp_ff;
  wire [12:0] pc_inc = pc_ff + 13'd1;
  wire [12:0] push_val = (core_cmd.op == OP_INVOKE) ? pc_inc : pc_ff;
  // Single page: the page bits are masked off before use
  wire [1:0] page = pc_latch_ff[4:3] & `PAGE_MASK;
  wire [12:0] branch_pc = {page, core_cmd.target};

  logic [12:0] nxt_pc;
  always_comb
  begin
    unique case (core_cmd.op)
      OP_NONE: nxt_pc = pc_ff;
      OP_STEP: nxt_pc = pc_inc;
      OP_INVOKE: nxt_pc = branch_pc;
      OP_JUMP: nxt_pc = branch_pc;
      OP_RETURN: nxt_pc = stack_ff[sp_dec];
      OP_VECTOR: nxt_pc = `IRQ_VECTOR;
      default: nxt_pc = pc_ff;
    endcase
    // A bus write of the low byte overrides the core operation
    if (wr_pc_low)
      nxt_pc = {pc_latch_ff[4:0], wbyte};
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      pc_ff <= `RST_PC;
      sp_ff <= 3'd0;
    end
    else
    begin
      pc_ff <= nxt_pc;
      sp_ff <= nxt_sp;
    end
  end

  // Stack lives outside the register map, so no bus path reaches it
  genvar gi;
  generate
    for (gi = 0; gi < `STACK_DEPTH; gi++)
    begin : g_stack
      always_ff @(posedge hclk or negedge hresetn)
      begin
        if (!hresetn)
          stack_ff[gi] <= `RST_PC;
        else if (do_push && sp_ff == 3'(gi))
          stack_ff[gi] <= push_val;
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Outputs

  assign hrdata = hrdata_ff;
  assign hreadyout = hready_ff;
  assign hresp = 1'b0;
  assign pc = pc_ff;
  assign irq_request = irq_ff;

endmodule : core_pc_stack_irq_control

// File: testbench/core_ctrl_chk.sv
// Port checks for the core control block
// Assumes hready is looped back from hreadyout
`timescale 1ns/10ps
module core_ctrl_chk (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [1:0] htrans,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire core_ctrl_pkg::core_cmd_t core_cmd,
  input wire logic [12:0] pc,
  input wire logic irq_request
);
  import core_ctrl_pkg::*;
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // Bus idle: no pc_low_byte write can override the op
  wire logic idle = hreadyout;
  wire logic [10:0] tgt = core_cmd.target;
  property p_okay; hresp == 1'b0; endproperty
  a_okay: assert property (p_okay) else $error("hresp not OKAY");
  property p_wait; (hsel && htrans[1] && hreadyout) |=> !hreadyout ##1 hreadyout; endproperty
  a_wait: assert property (p_wait) else $error("wait state wrong");
  property p_reset; $rose(hresetn) |-> pc == 13'h0000 && !irq_request; endproperty
  a_reset: assert property (p_reset) else $error("pc not cleared by reset");
  property p_step; (core_cmd.op == OP_STEP && idle) |=> pc == $past(pc) + 13'h0001; endproperty
  a_step: assert property (p_step) else $error("step wrong");
  property p_hold; (core_cmd.op == OP_NONE && idle) |=> pc == $past(pc); endproperty
  a_hold: assert property (p_hold) else $error("pc moved");
  property p_jump; (core_cmd.op == OP_JUMP && idle) |=> pc == {2'b00, $past(tgt)}; endproperty
  a_jump: assert property (p_jump) else $error("jump wrong");
  property p_vector; (core_cmd.op == OP_VECTOR && idle) |=> pc == 13'h0004; endproperty
  a_vector: assert property (p_vector) else $error("vector wrong");
  property p_call;
    (core_cmd.op == OP_INVOKE && idle) ##1 (core_cmd.op == OP_RETURN && idle) |=> pc == $past(pc, 2) + 13'h0001;
  endproperty
  a_call: assert property (p_call) else $error("call return wrong");
endmodule : core_ctrl_chk

bind core_pc_stack_irq_control core_ctrl_chk core_ctrl_chk_inst (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
  .htrans(htrans), .hreadyout(hreadyout), .hresp(hresp), .core_cmd(core_cmd), .pc(pc), .irq_request(irq_request));

// File: testbench/core_model.sv
// Instruction execution side: one core operation per call
// Assumes the caller keeps ops apart from pc_low_byte writes
`timescale 1ns/10ps
module core_model (
  input wire logic hclk,
  output core_ctrl_pkg::core_cmd_t core_cmd
);
  import core_ctrl_pkg::*;
  initial core_cmd = '{OP_NONE, 11'h000};
  // Op stands until the next call
  task automatic issue(input core_op_t op, input logic [10:0] target);
    @(posedge hclk);
    core_cmd <= '{op, target};
  endtask : issue
endmodule : core_model

// File: testbench/tb_top.sv
// Self-checking bench: register bus, core ops, interrupt events
// Assumes one clock; hready looped back from hreadyout
`timescale 1ns/10ps
`include "core_ctrl_regs.svh"
module tb_top;
  import core_ctrl_pkg::*;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0000_0000;
  logic [1:0] htrans = 2'b00;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0000_0000;
  logic [31:0] hrdata;
  logic hreadyout;
  logic hresp;
  core_cmd_t core_cmd;
  irq_events_t events = '0;
  logic [12:0] pc;
  logic irq_request;
  logic [7:0] rd;
  int miscompares = 0;
  int n_checks = 0;
  always #2.5 hclk = ~hclk;
  core_pc_stack_irq_control core_pc_stack_irq_control_inst (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'b010), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .core_cmd(core_cmd), .events(events), .pc(pc),
    .irq_request(irq_request));
  core_model core_model_inst (.hclk(hclk), .core_cmd(core_cmd));
  ////////////////////////////////////////////////////////////////
  task automatic chk_reg(input logic [12:0] got, input logic [12:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      miscompares++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_reg
  task automatic chk_pc(input logic [12:0] exp);
    @(negedge hclk);
    chk_reg(pc, exp);
  endtask : chk_pc
  task automatic bus(input logic [7:0] idx, input logic wr, input logic [7:0] wd);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= {22'h00_0000, idx, 2'b00};
    htrans <= 2'b10;
    hwrite <= wr;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= {24'h00_0000, wd};
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata[7:0];
  endtask : bus
  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    bus(idx, 1'b1, d);
  endtask : wr
  task automatic rd_chk(input logic [7:0] idx, input logic [7:0] exp);
    bus(idx, 1'b0, 8'h00);
    chk_reg({5'h00, rd}, {5'h00, exp});
  endtask : rd_chk
  task automatic op(input core_op_t o, input logic [10:0] t);
    core_model_inst.issue(o, t);
  endtask : op
  task automatic ev(input irq_events_t e);
    @(posedge hclk);
    events <= e;
    @(posedge hclk);
    events <= '0;
    repeat (3) @(posedge hclk);
  endtask : ev
  task automatic irq_chk(input logic exp);
    repeat (3) @(posedge hclk);
    @(negedge hclk);
    chk_reg({12'h000, irq_request}, {12'h000, exp});
  endtask : irq_chk
  task automatic end_sim;
    $display("checks=%0d miscompares=%0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : end_sim
  ////////////////////////////////////////////////////////////////
  initial
  begin
    #200000;
    miscompares++;
    end_sim;
  end
  initial
  begin
    repeat (20) @(posedge hclk);
    hresetn <= 1'b1;
    chk_pc(13'h0000);
    rd_chk(8'h3f, 8'h00);
    wr(`IDX_PC_LATCH, 8'h1f);
    wr(`IDX_PC_LOW, 8'h34);
    chk_pc(13'h1f34);
    op(OP_STEP, 11'h000);
    op(OP_NONE, 11'h000);
    chk_pc(13'h1f35);
    op(OP_JUMP, 11'h5a5);
    op(OP_NONE, 11'h000);
    chk_pc(13'h05a5);
    op(OP_JUMP, 11'h000);
    for (int k = 1; k <= 9; k++)
      op(OP_INVOKE, 11'(k * 8));
    for (int i = 0; i < 8; i++)
    begin
      op(OP_RETURN, 11'h000);
      op(OP_NONE, 11'h000);
      chk_pc(13'((8 - i) * 8 + 1));
    end
    rd_chk(`IDX_PC_LATCH, 8'h1f);
    op(OP_INVOKE, 11'h100);
    op(OP_RETURN, 11'h000);
    op(OP_NONE, 11'h000);
    chk_pc(13'h000a);
    op(OP_VECTOR, 11'h000);
    op(OP_NONE, 11'h000);
    chk_pc(13'h0004);
    op(OP_RETURN, 11'h000);
    op(OP_NONE, 11'h000);
    chk_pc(13'h000a);
    wr(`IDX_POINTER, `IDX_PC_LATCH);
    wr(`IDX_WINDOW, 8'h05);
    rd_chk(`IDX_PC_LATCH, 8'h05);
    wr(`IDX_BANK_SEL, 8'h80);
    rd_chk(`IDX_WINDOW, 8'h00);
    wr(`IDX_BANK_SEL, 8'h00);
    wr(`IDX_POINTER, 8'h00);
    wr(`IDX_WINDOW, 8'h77);
    rd_chk(`IDX_WINDOW, 8'h00);
    ev('{timer_overflow: 1'b1, default: '0});
    rd_chk(`IDX_IRQ_CTRL, 8'h04);
    irq_chk(1'b0);
    wr(`IDX_IRQ_CTRL, 8'ha4);
    irq_chk(1'b1);
    wr(`IDX_IRQ_CTRL, 8'h00);
    ev('{ext_pin_event: 1'b1, default: '0});
    ev('{pins: 3'b100, default: '0});
    rd_chk(`IDX_IRQ_CTRL, 8'h03);
    wr(`IDX_IRQ_CTRL, 8'h92);
    irq_chk(1'b1);
    wr(`IDX_IRQ_CTRL, 8'h89);
    irq_chk(1'b1);
    wr(`IDX_PIRQ_FLAGS, 8'h00);
    wr(`IDX_PIRQ_ENABLES, 8'h01);
    ev('{periph_set: 8'h01, default: '0});
    rd_chk(`IDX_PIRQ_FLAGS, 8'h01);
    wr(`IDX_IRQ_CTRL, 8'h80);
    irq_chk(1'b0);
    wr(`IDX_IRQ_CTRL, 8'hc0);
    irq_chk(1'b1);
    end_sim;
  end
endmodule : tb_top
